// ==== tgp_pkg.sv ====
package tgp_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam logic [31:0] PORT_A_DATA_ADDR = 32'h0400_0120;
  localparam logic [31:0] PORT_B_DATA_ADDR = 32'h0400_0122;
  localparam logic [31:0] PORT_C_DATA_ADDR = 32'h0400_0124;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int unsigned NPORT = 3;
  localparam int unsigned NPIN = 8;
  // ----------------------------------------
  // Function-select codes
  // ----------------------------------------
  localparam logic [1:0] SEL_ALT = 2'h0;
  localparam logic [1:0] SEL_OUT = 2'h1;
  localparam logic [1:0] SEL_IN_PU = 2'h2;
  localparam logic [1:0] SEL_IN_NOPU = 2'h3;
  localparam int unsigned SEL_HI_BIT = 1;
  // Port C control powers up as input with pull-up
  localparam logic [15:0] PORT_C_SEL_RESET = 16'hAAAA;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tgp_bus_req_t;

  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] oe_b;
    logic [7:0] pull_up;
  } tgp_pin_ctl_t;
endpackage

// ==== tgp_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
module tgp_sync (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_level
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] level;
  } tgp_sync_state_t;

  tgp_sync_state_t state;
  tgp_sync_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.s1 = pin_in;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    // Change counts only once stages two and three agree, filtering single-cycle glitches
    for (int i = 0; i < 8; i++) begin
      if (state.s2[i] == state.s3[i]) begin
        next_state.level[i] = state.s2[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pin_level = state.level;
endmodule
`default_nettype wire

// ==== tgp_pin_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Per-port pin driver and pull-up control
// ----------------------------------------
module tgp_pin_ctl (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] data,
  input wire logic [15:0] func_sel,
  output var tgp_pkg::tgp_pin_ctl_t pin_ctl
);
  tgp_pkg::tgp_pin_ctl_t state;
  tgp_pkg::tgp_pin_ctl_t next_state;

  always_comb begin
    next_state = state;
    for (int i = 0; i < 8; i++) begin
      next_state.drive[i] = data[i];
      next_state.oe_b[i] = (func_sel[2*i +: 2] != tgp_pkg::SEL_OUT);
      next_state.pull_up[i] = (func_sel[2*i +: 2] == tgp_pkg::SEL_IN_PU);
    end
  end

  // Reset leaves every pin released, pull-ups off, until control settles
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{drive: 8'h00, oe_b: 8'hff, pull_up: 8'h00};
    end else begin
      state <= next_state;
    end
  end

  assign pin_ctl = state;
endmodule
`default_nettype wire

// ==== tgp_gpio_ports.sv ====
`timescale 1ns/100ps
`default_nettype none
module tgp_gpio_ports (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [31:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic [15:0] port_a_function_ctrl,
  input wire logic [15:0] port_b_function_ctrl,
  input wire logic [15:0] port_c_function_ctrl,
  input wire logic [7:0] port_a_pin_in,
  input wire logic [7:0] port_b_pin_in,
  input wire logic [7:0] port_c_pin_in,
  output logic [7:0] port_a_pin_out,
  output logic [7:0] port_a_pin_oe_b,
  output logic [7:0] port_a_pull_up,
  output logic [7:0] port_b_pin_out,
  output logic [7:0] port_b_pin_oe_b,
  output logic [7:0] port_b_pull_up,
  output logic [7:0] port_c_pin_out,
  output logic [7:0] port_c_pin_oe_b,
  output logic [7:0] port_c_pull_up
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] port_a_data;
    logic [7:0] port_b_data;
    logic [7:0] port_c_data;
    logic [7:0] rdata;
  } tgp_regs_t;

  tgp_regs_t state;
  tgp_regs_t next_state;
  tgp_pkg::tgp_bus_req_t req;
  logic [7:0] lvl_a;
  logic [7:0] lvl_b;
  logic [7:0] lvl_c;
  logic [15:0] sel_c;
  logic por_done;
  tgp_pkg::tgp_pin_ctl_t ctl_a;
  tgp_pkg::tgp_pin_ctl_t ctl_b;
  tgp_pkg::tgp_pin_ctl_t ctl_c;

  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  // Read mux: input-coded pins return the pin level, others the stored bit
  function automatic logic [7:0] read_view(input logic [7:0] data, input logic [7:0] lvl,
                                           input logic [15:0] sel);
    logic [7:0] v;
    v = data;
    for (int i = 0; i < 8; i++) begin
      if (sel[2*i + tgp_pkg::SEL_HI_BIT]) begin
        v[i] = lvl[i];
      end
    end
    return v;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  tgp_sync u_sync_a (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(port_a_pin_in), .pin_level(lvl_a));
  tgp_sync u_sync_b (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(port_b_pin_in), .pin_level(lvl_b));
  tgp_sync u_sync_c (.ref_clk(ref_clk), .rst_b(rst_b), .pin_in(port_c_pin_in), .pin_level(lvl_c));

  // ----------------------------------------
  // Port C power-on default
  // ----------------------------------------
  // Controller registers may not yet be valid right after reset, so port C's select is forced to input-with-pull-up until the
  // first clock after release; the pins, pull-ups off in reset, show that code from the first clock to the second, then the supplied code rules.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      por_done <= 1'b0;
    end else begin
      por_done <= 1'b1;
    end
  end
  assign sel_c = por_done ? port_c_function_ctrl : tgp_pkg::PORT_C_SEL_RESET;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.rdata = 8'h00;
    if (req.wr) begin
      unique case (req.addr)
        tgp_pkg::PORT_A_DATA_ADDR: next_state.port_a_data = req.wdata;
        tgp_pkg::PORT_B_DATA_ADDR: next_state.port_b_data = req.wdata;
        tgp_pkg::PORT_C_DATA_ADDR: next_state.port_c_data = req.wdata;
        default: next_state = next_state;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        tgp_pkg::PORT_A_DATA_ADDR: next_state.rdata = read_view(state.port_a_data, lvl_a, port_a_function_ctrl);
        tgp_pkg::PORT_B_DATA_ADDR: next_state.rdata = read_view(state.port_b_data, lvl_b, port_b_function_ctrl);
        tgp_pkg::PORT_C_DATA_ADDR: next_state.rdata = read_view(state.port_c_data, lvl_c, sel_c);
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  // Only power-on reset reaches these flops; manual reset and sleep have no path in
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{port_a_data: tgp_pkg::DATA_RESET, port_b_data: tgp_pkg::DATA_RESET,
                 port_c_data: tgp_pkg::DATA_RESET, rdata: 8'h00};
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Pin control
  // ----------------------------------------
  tgp_pin_ctl u_ctl_a (.ref_clk(ref_clk), .rst_b(rst_b), .data(state.port_a_data),
                       .func_sel(port_a_function_ctrl), .pin_ctl(ctl_a));
  tgp_pin_ctl u_ctl_b (.ref_clk(ref_clk), .rst_b(rst_b), .data(state.port_b_data),
                       .func_sel(port_b_function_ctrl), .pin_ctl(ctl_b));
  tgp_pin_ctl u_ctl_c (.ref_clk(ref_clk), .rst_b(rst_b), .data(state.port_c_data),
                       .func_sel(sel_c), .pin_ctl(ctl_c));

  assign bus_rdata = state.rdata;
  assign port_a_pin_out = ctl_a.drive;
  assign port_a_pin_oe_b = ctl_a.oe_b;
  assign port_a_pull_up = ctl_a.pull_up;
  assign port_b_pin_out = ctl_b.drive;
  assign port_b_pin_oe_b = ctl_b.oe_b;
  assign port_b_pull_up = ctl_b.pull_up;
  assign port_c_pin_out = ctl_c.drive;
  assign port_c_pin_oe_b = ctl_c.oe_b;
  assign port_c_pull_up = ctl_c.pull_up;
endmodule
`default_nettype wire

// ==== tgp_chk_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----
// Port data checks
// ----
module tgp_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [31:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [15:0] port_a_function_ctrl,
  input wire logic [15:0] port_b_function_ctrl,
  input wire logic [15:0] port_c_function_ctrl,
  input wire logic [7:0] port_c_pin_in,
  input wire logic [7:0] port_a_pin_out,
  input wire logic [7:0] port_b_pin_out,
  input wire logic [7:0] port_c_pin_out,
  input wire logic [7:0] port_a_pin_oe_b,
  input wire logic [7:0] port_a_pull_up,
  input wire logic [7:0] port_c_pull_up
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_wr_b;
    bus_wr && bus_addr == tgp_pkg::PORT_B_DATA_ADDR;
  endsequence
  sequence s_rd_b;
    bus_rd && bus_addr == tgp_pkg::PORT_B_DATA_ADDR && (port_b_function_ctrl & 16'hAAAA) == 16'h0000;
  endsequence
  a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 8'h00) else $error("rdata not idle");
  a_unmapped_zero: assert property (bus_rd && bus_addr[31:3] != 29'h0080_0024 |=> bus_rdata == 8'h00)
    else $error("unmapped read");
  a_write_readback: assert property (s_wr_b ##2 s_rd_b |=> bus_rdata == $past(bus_wdata, 3))
    else $error("readback");
  a_oe_tracks_code: assert property ($past(rst_b) |-> port_a_pin_oe_b[0] == ($past(port_a_function_ctrl[1:0]) != 2'h1))
    else $error("oe code");
  a_pull_code: assert property ($past(rst_b) |-> port_a_pull_up[0] == ($past(port_a_function_ctrl[1:0]) == 2'h2))
    else $error("pull code");
  a_pin_follows: assert property (bus_wr && bus_addr == tgp_pkg::PORT_A_DATA_ADDR |-> ##2 port_a_pin_out == $past(bus_wdata, 2))
    else $error("pin out");
  a_input_level: assert property ($stable(port_c_pin_in)[*8] ##0 bus_rd && bus_addr == tgp_pkg::PORT_C_DATA_ADDR
    && port_c_function_ctrl == 16'hAAAA |=> bus_rdata == $past(port_c_pin_in)) else $error("pin level");
  a_reset_clear: assert property ($rose(rst_b) |-> {port_a_pin_out, port_b_pin_out, port_c_pin_out} == 24'h00_0000)
    else $error("reset clear");
  a_port_c_boot: assert property ($rose(rst_b) |=> port_c_pull_up == 8'hFF) else $error("port c boot");
endmodule
bind tgp_gpio_ports tgp_chk tgp_chk_inst (.*);
`default_nettype wire

// ==== tgp_board.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----
// Board pin model
// ----
module tgp_board (
  input wire logic ref_clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_b,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  output logic [7:0] level
);
  // Floating pins toggle every cycle, so the synchroniser never accepts them and holds the last stable level
  logic [7:0] drift = 8'h00;
  always @(posedge ref_clk) drift <= ~drift;
  assign level = (~pin_oe_b & pin_out) | (pin_oe_b & ext_en & ext) | (pin_oe_b & ~ext_en & (pull_up | drift));
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [31:0] PA = tgp_pkg::PORT_A_DATA_ADDR;
  localparam logic [31:0] PB = tgp_pkg::PORT_B_DATA_ADDR;
  localparam logic [31:0] PC = tgp_pkg::PORT_C_DATA_ADDR;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] bus_addr = 32'h0000_0000;
  logic [7:0] bus_wdata = 8'h00, bus_rdata;
  logic bus_wr = 1'b0, bus_rd = 1'b0;
  logic [15:0] port_a_function_ctrl = 16'h5555, port_b_function_ctrl = 16'h0000, port_c_function_ctrl = 16'hAAAA;
  logic [7:0] ext_a = 8'h00, en_a = 8'h00, port_a_pin_in, port_b_pin_in, port_c_pin_in;
  logic [7:0] port_a_pin_out, port_b_pin_out, port_c_pin_out, port_a_pin_oe_b, port_b_pin_oe_b, port_c_pin_oe_b;
  logic [7:0] port_a_pull_up, port_b_pull_up, port_c_pull_up;
  int err_total = 0;
  int n_checks = 0;
  tgp_gpio_ports tgp_gpio_ports_inst (.*);
  tgp_board brd_a_inst (.ref_clk, .pin_out(port_a_pin_out), .pin_oe_b(port_a_pin_oe_b), .pull_up(port_a_pull_up),
    .ext(ext_a), .ext_en(en_a), .level(port_a_pin_in));
  tgp_board brd_b_inst (.ref_clk, .pin_out(port_b_pin_out), .pin_oe_b(port_b_pin_oe_b), .pull_up(port_b_pull_up),
    .ext(8'h00), .ext_en(8'h00), .level(port_b_pin_in));
  tgp_board brd_c_inst (.ref_clk, .pin_out(port_c_pin_out), .pin_oe_b(port_c_pin_oe_b), .pull_up(port_c_pull_up),
    .ext(8'h5A), .ext_en(8'hFF), .level(port_c_pin_in));
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rdc(input logic [31:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, e);
  endtask
  task automatic t_power_on;
    repeat (8) @(posedge ref_clk);
    rdc(PA, 8'h00);
    rdc(PB, 8'h00);
    rdc(PC, 8'h5A);
    chk(port_c_pull_up, 8'hFF);
    chk(port_c_pin_oe_b, 8'hFF);
  endtask
  task automatic t_output;
    wr(PA, 8'hA5);
    rdc(PA, 8'hA5);
    chk(port_a_pin_out, 8'hA5);
    chk(port_a_pin_oe_b, 8'h00);
    rdc(32'h0400_0126, 8'h00);
    wr(32'h0400_0121, 8'hFF);
    rdc(PA, 8'hA5);
  endtask
  task automatic t_alt;
    wr(PB, 8'h3C);
    rdc(PB, 8'h3C);
    chk(port_b_pin_oe_b, 8'hFF);
    chk(port_b_pull_up, 8'h00);
    @(posedge ref_clk);
    port_c_function_ctrl <= 16'h5555;
    wr(PC, 8'h96);
    rdc(PC, 8'h96);
    chk(port_c_pin_out, 8'h96);
    chk(port_c_pin_oe_b, 8'h00);
    @(posedge ref_clk);
    port_c_function_ctrl <= 16'hAAAA;
  endtask
  // Sync delay is a few cycles, so each pin change is given eight
  task automatic t_input;
    @(posedge ref_clk);
    port_a_function_ctrl <= 16'hFFFF;
    ext_a <= 8'hC3;
    en_a <= 8'hFF;
    wr(PA, 8'h11);
    repeat (8) @(posedge ref_clk);
    rdc(PA, 8'hC3);
    chk(port_a_pin_oe_b | ~port_a_pull_up, 8'hFF);
    @(posedge ref_clk);
    port_a_function_ctrl <= 16'hAAAA;
    en_a <= 8'h00;
    repeat (8) @(posedge ref_clk);
    rdc(PA, 8'hFF);
    @(posedge ref_clk);
    port_a_function_ctrl <= 16'h5555;
    rdc(PA, 8'h11);
  endtask
  task automatic t_rearm;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdc(PA, 8'h00);
    chk(port_a_pin_out, 8'h00);
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_power_on;
    t_output;
    t_alt;
    t_input;
    t_rearm;
    results;
  end
  initial begin
    #100000;
    err_total++;
    results;
  end
endmodule
`default_nettype wire
